// ==== btp_pkg.sv ====
// Shared constants and types for the branch target predictor
package btp_pkg;
  localparam int BTP_AW       = 32;
  localparam int BTP_SETS     = 128;
  localparam int BTP_IDX_W    = 7;
  localparam int BTP_TAG_W    = BTP_AW - BTP_IDX_W;
  // Register byte offsets
  localparam logic [3:0] BTP_OFS_CFG   = 4'h0;
  localparam logic [3:0] BTP_OFS_LSTRT = 4'h4;
  localparam logic [3:0] BTP_OFS_LEND  = 4'h8;
  localparam logic [3:0] BTP_OFS_STAT  = 4'hc;
  // Config field positions
  localparam int BTP_CFG_EN    = 0;
  localparam int BTP_CFG_FRZ   = 1;
  localparam int BTP_CFG_LOCK  = 2;
  localparam int BTP_CFG_RET   = 3;
  localparam int BTP_CFG_VLEN  = 4;
  localparam logic [4:0] BTP_CFG_RST = 5'h09;
  // Masking counts
  localparam logic [1:0] BTP_TAKEN_SKIP = 2'h2;
  localparam logic [3:0] BTP_LOOP_SKIP  = 4'ha;
  localparam logic [3:0] BTP_LOOP_TAIL  = 4'h3;
  localparam logic [3:0] BTP_LOOP_TGT   = 4'ha;
  localparam logic [1:0] BTP_HIT_DELAY  = 2'h2;
  // Stall costs
  localparam logic [3:0] BTP_COST_HIT_ND  = 4'h2;
  localparam logic [3:0] BTP_COST_MISS    = 4'hb;
  localparam logic [3:0] BTP_COST_NT_DB   = 4'h9;
  localparam logic [1:0] BTP_CNT_RST      = 2'h1;

  typedef enum logic [1:0] {
    BTP_IDLE = 2'b00,
    BTP_WAIT = 2'b01,
    BTP_ISSUE = 2'b10
  } btp_state_e;

  typedef struct packed {
    logic                 valid;
    logic [BTP_TAG_W-1:0] tag;
    logic [BTP_AW-1:0]    target;
    logic [1:0]           cnt;
    logic                 lock;
    logic                 is_ret;
  } btp_entry_s;

  function automatic logic btp_taken(input logic [1:0] c);
    return c[1];
  endfunction

  function automatic logic [1:0] btp_sat(input logic [1:0] c, input logic up);
    if (up) return (c == 2'h3) ? c : c + 2'h1;
    return (c == 2'h0) ? c : c - 2'h1;
  endfunction
endpackage

// ==== btp_seq_model.sv ====
// Fetch and branch verification model on the far side of the predictor
`timescale 1ns/1ps
module btp_seq_model
  import btp_pkg::*;
(
  input  wire logic         clk_sys,
  output logic              fetch_valid,
  output logic [BTP_AW-1:0] fetch_addr,
  output logic [1:0]        fetch_len,
  output logic              res_valid,
  output logic [BTP_AW-1:0] res_addr,
  output logic [BTP_AW-1:0] res_target,
  output logic [4:0]        res_f,
  output logic [4:0]        pipe_f
);
  initial begin
    fetch_valid = 1'b0;
    res_valid = 1'b0;
    {fetch_addr, res_addr, res_target} = '0;
    {fetch_len, res_f, pipe_f} = '0;
  end

  // Full-width fetches only, so no two branches share one window
  task automatic fetch(input logic [BTP_AW-1:0] a);
    @(posedge clk_sys);
    fetch_valid <= 1'b1;
    fetch_addr <= a;
    fetch_len <= 2'h3;
    @(posedge clk_sys);
    fetch_valid <= 1'b0;
    fetch_addr <= ~a;
  endtask

  // Flags: taken, return, predicted taken, delayed, conditional
  task automatic resolve(input logic [BTP_AW-1:0] a, t,
                         input logic [4:0] f);
    @(posedge clk_sys);
    res_valid <= 1'b1;
    res_addr <= a;
    res_target <= t;
    res_f <= f;
    @(posedge clk_sys);
    res_valid <= 1'b0;
    res_addr <= ~a;
    res_target <= ~t;
    // Straight-line code after every branch before the next one
    repeat (12) @(posedge clk_sys);
  endtask

  task automatic flags(input logic [4:0] f);
    @(posedge clk_sys);
    pipe_f <= f;
  endtask
endmodule

// ==== btp_store.sv ====
// Two-way entry store with per-set replacement bit
`timescale 1ns/1ps
module btp_store
  import btp_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  btp_upd_if.dst                    upd,
  input  wire logic [BTP_IDX_W-1:0] rd_idx,
  output btp_entry_s                rd_e0,
  output btp_entry_s                rd_e1,
  output logic                      rd_lru
);
  btp_entry_s way0 [BTP_SETS];
  btp_entry_s way1 [BTP_SETS];
  logic [BTP_SETS-1:0] lru;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lru <= '0;
      for (int i = 0; i < BTP_SETS; i++) begin
        way0[i] <= '0;
        way1[i] <= '0;
      end
    end else begin
      if (upd.we && !upd.way) begin
        way0[upd.idx] <= upd.entry;
      end
      if (upd.we && upd.way) begin
        way1[upd.idx] <= upd.entry;
      end
      if (upd.lru_we) begin
        lru[upd.idx] <= upd.lru_val;
      end
    end
  end

  assign rd_e0  = way0[rd_idx];
  assign rd_e1  = way1[rd_idx];
  assign rd_lru = lru[rd_idx];
endmodule

// ==== btp_top.sv ====
// Branch predictor and target buffer top level
`timescale 1ns/1ps
// What this block does
// - Enable bit clear stops all lookups, updates and any prediction not yet in issue state
// - Freeze keeps predicting but changes no entry, counter or LRU
// - With lock on, branches in range are stored and never evicted
// - Returns take target from call stack unless that bit is cleared
// - After a taken prediction, skip the next two fetch addresses
// - Update while branch in last execute stage masks fetch slot
// - Withhold prediction for ten fetches after a loop setup
// - Branches in the last three loop instructions are not predicted
// - Loop-tail targets masked only inside an active loop with a return ahead
// - Return fetched with call or return in flight is not predicted
// - Loop-stack manipulation in pipeline suppresses all prediction
// - Predicted target issues three cycles after lookup
// - Mispredict costs eleven cycles, or nine delayed not-taken
// - Direct targets from sequencer, indirect from address generator
// - Variable-length PC steps one, two or three short words
// - Variable-length indirect modify counts short-word units
// - Store is two ways of 128 sets, valid, LRU, 2-bit counter
// - Counter 10 or 11 predicts taken
// - Counter moves on validation; taken misses allocate at final stage
// - Replace least recently used way of the set
module btp_top
  import btp_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              fetch_valid,
  input  wire logic [BTP_AW-1:0] fetch_addr,
  input  wire logic [1:0]        fetch_len,
  input  wire logic              fetch_is_ret,
  input  wire logic              call_ret_in_pipe,
  input  wire logic              loop_stack_in_pipe,
  input  wire logic              loop_setup,
  input  wire logic              loop_active,
  input  wire logic [BTP_AW-1:0] loop_end_addr,
  input  wire logic              ret_ahead,
  input  wire logic [BTP_AW-1:0] ret_stack_top,
  input  wire logic              res_valid,
  input  wire logic [BTP_AW-1:0] res_addr,
  input  wire logic [BTP_AW-1:0] res_target,
  input  wire logic              res_taken,
  input  wire logic              res_is_ret,
  input  wire logic              res_pred_taken,
  input  wire logic              res_delayed,
  input  wire logic              res_cond,
  input  wire logic              ind_sel,
  input  wire logic [BTP_AW-1:0] ind_index,
  input  wire logic [BTP_AW-1:0] ind_modify,
  input  wire logic [BTP_AW-1:0] dir_base,
  input  wire logic [BTP_AW-1:0] dir_offset,
  input  wire logic              dir_rel,
  output logic                   pred_valid,
  output logic                   pred_taken,
  output logic [BTP_AW-1:0]      pred_target,
  output logic [3:0]             stall_cycles,
  output logic                   stall_valid,
  output logic [BTP_AW-1:0]      next_pc,
  output logic [BTP_AW-1:0]      resolved_target
);
  logic [4:0]        cfg;
  logic [BTP_AW-1:0] lock_lo;
  logic [BTP_AW-1:0] lock_hi;
  btp_entry_s        e0;
  btp_entry_s        e1;
  logic              lru_bit;
  btp_upd_if         upd ();

  typedef struct packed {
    btp_state_e        st;
    logic [1:0]        skip;
    logic [3:0]        loop_skip;
    logic [1:0]        dly;
    logic              h_taken;
    logic [BTP_AW-1:0] h_target;
    logic              pv;
    logic              pt;
    logic [BTP_AW-1:0] ptgt;
    logic [3:0]        stall;
    logic              stv;
    logic [BTP_AW-1:0] pc;
    logic [BTP_AW-1:0] rtgt;
    logic [7:0]        stat;
  } btp_core_s;
  btp_core_s r;
  btp_core_s next_r;

  btp_wb u_wb (
    .clk_sys              (clk_sys),
    .reset                (reset),
    .wb_cyc_i             (wb_cyc_i),
    .wb_stb_i             (wb_stb_i),
    .wb_we_i              (wb_we_i),
    .wb_adr_i             (wb_adr_i),
    .wb_dat_i             (wb_dat_i),
    .wb_sel_i             (wb_sel_i),
    .stat_in              (r.stat),
    .wb_dat_o             (wb_dat_o),
    .wb_ack_o             (wb_ack_o),
    .predictor_config_reg (cfg),
    .lock_range_start_reg (lock_lo),
    .lock_range_end_reg   (lock_hi)
  );

  // One read port shared by lookup and update; update wins the port
  logic [BTP_IDX_W-1:0] rd_idx;
  assign rd_idx = res_valid ? res_addr[BTP_IDX_W-1:0]
                            : fetch_addr[BTP_IDX_W-1:0];

  btp_store u_store (
    .clk_sys (clk_sys),
    .reset   (reset),
    .upd     (upd),
    .rd_idx  (rd_idx),
    .rd_e0   (e0),
    .rd_e1   (e1),
    .rd_lru  (lru_bit)
  );

  function automatic logic in_lock(input logic [BTP_AW-1:0] a,
                                   input logic [BTP_AW-1:0] lo,
                                   input logic [BTP_AW-1:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic near_end(input logic [BTP_AW-1:0] a,
                                    input logic [BTP_AW-1:0] e,
                                    input logic [3:0] n);
    logic [BTP_AW-1:0] d;
    d = e - a;
    return (a <= e) && (d < {{(BTP_AW-4){1'b0}}, n});
  endfunction

  logic en;
  logic frz;
  logic upd_busy;
  logic hit0;
  logic hit1;
  logic hit;
  logic rhit0;
  logic rhit1;
  logic mask;
  btp_entry_s hent;

  assign en   = cfg[BTP_CFG_EN];
  assign frz  = cfg[BTP_CFG_FRZ];
  assign upd_busy = en && res_valid && !frz;
  assign hit0 = e0.valid && e0.tag == fetch_addr[BTP_AW-1:BTP_IDX_W];
  assign hit1 = e1.valid && e1.tag == fetch_addr[BTP_AW-1:BTP_IDX_W];
  assign rhit0 = e0.valid && e0.tag == res_addr[BTP_AW-1:BTP_IDX_W];
  assign rhit1 = e1.valid && e1.tag == res_addr[BTP_AW-1:BTP_IDX_W];
  assign hit  = hit0 || hit1;
  assign hent = hit0 ? e0 : e1;

  always_comb begin
    logic tgt_tail;
    logic [BTP_AW-1:0] tgt;
    logic [BTP_AW-1:0] step;
    btp_entry_s ne;
    logic vw;
    next_r = r;
    tgt = hent.target;
    tgt_tail = near_end(tgt, loop_end_addr, BTP_LOOP_TGT);
    ne = '0;
    vw = 1'b0;
    step = '0;
    upd.we = 1'b0;
    upd.idx = res_addr[BTP_IDX_W-1:0];
    upd.way = 1'b0;
    upd.entry = '0;
    upd.lru_we = 1'b0;
    upd.lru_val = 1'b0;

    mask = r.skip != 2'h0;
    mask = mask || upd_busy;
    mask = mask || r.loop_skip != 4'h0 || loop_setup;
    mask = mask || (loop_active &&
           near_end(fetch_addr, loop_end_addr, BTP_LOOP_TAIL));
    // A target inside the active loop tail is kept only with no return ahead
    mask = mask || (loop_active && tgt_tail && ret_ahead);
    mask = mask || (fetch_is_ret && call_ret_in_pipe);
    mask = mask || loop_stack_in_pipe;

    next_r.pv = 1'b0;
    next_r.stv = 1'b0;
    // Counts fetches, not cycles, so an idle gap cannot use up the window
    if (r.skip != 2'h0 && fetch_valid) next_r.skip = r.skip - 2'h1;
    if (r.loop_skip != 4'h0 && fetch_valid) begin
      next_r.loop_skip = r.loop_skip - 4'h1;
    end
    if (loop_setup) next_r.loop_skip = BTP_LOOP_SKIP;

    unique case (r.st)
      BTP_IDLE: begin
        if (en && fetch_valid && !mask && hit) begin
          next_r.h_taken = btp_taken(hent.cnt);
          // Returns are poorly served by history, use the call stack
          next_r.h_target = (hent.is_ret && cfg[BTP_CFG_RET])
                            ? ret_stack_top : hent.target;
          next_r.dly = BTP_HIT_DELAY - 2'h1;
          next_r.st = BTP_WAIT;
          if (btp_taken(hent.cnt)) next_r.skip = BTP_TAKEN_SKIP;
        end
      end
      BTP_WAIT: begin
        next_r.dly = r.dly - 2'h1;
        if (r.dly == 2'h1) next_r.st = BTP_ISSUE;
      end
      BTP_ISSUE: begin
        next_r.pv = 1'b1;
        next_r.pt = r.h_taken;
        next_r.ptgt = r.h_target;
        next_r.st = BTP_IDLE;
      end
      default: next_r.st = BTP_IDLE;
    endcase
    if (!en) next_r.st = BTP_IDLE;

    if (upd_busy) begin
      if (rhit0 || rhit1) begin
        ne = rhit0 ? e0 : e1;
        ne.cnt = btp_sat(ne.cnt, res_taken);
        upd.we = 1'b1;
        upd.way = rhit1 && !rhit0;
        upd.entry = ne;
        upd.lru_we = 1'b1;
        upd.lru_val = !(rhit1 && !rhit0);
      end else if (res_taken) begin
        vw = lru_bit;
        if ((vw ? e1.lock : e0.lock)) vw = !vw;
        if (!(vw ? e1.lock : e0.lock)) begin
          ne.valid = 1'b1;
          ne.tag = res_addr[BTP_AW-1:BTP_IDX_W];
          ne.target = res_target;
          ne.cnt = BTP_CNT_RST;
          ne.is_ret = res_is_ret;
          ne.lock = cfg[BTP_CFG_LOCK] &&
                    in_lock(res_addr, lock_lo, lock_hi);
          upd.we = 1'b1;
          upd.way = vw;
          upd.entry = ne;
          upd.lru_we = 1'b1;
          upd.lru_val = !vw;
        end
      end
    end

    if (en && res_valid && res_cond) begin
      next_r.stv = 1'b1;
      if (res_pred_taken == res_taken) begin
        next_r.stall = (res_taken && !res_delayed)
                       ? BTP_COST_HIT_ND : 4'h0;
      end else if (res_pred_taken) begin
        next_r.stall = BTP_COST_MISS;
      end else begin
        next_r.stall = res_delayed ? BTP_COST_NT_DB : BTP_COST_MISS;
      end
    end

    // Short-word stepping only when variable-length mode is on
    step = cfg[BTP_CFG_VLEN] ? {{(BTP_AW-2){1'b0}}, fetch_len}
                             : {{(BTP_AW-1){1'b0}}, 1'b1};
    if (fetch_valid) next_r.pc = fetch_addr + step;

    // Modify is a raw short-word count in variable-length mode
    if (ind_sel) begin
      next_r.rtgt = ind_index + ind_modify;
    end else begin
      next_r.rtgt = dir_rel ? dir_base + dir_offset : dir_offset;
    end
    if (ind_sel && !cfg[BTP_CFG_VLEN]) begin
      next_r.rtgt = ind_index + ind_modify * 32'd3;
    end

    next_r.stat = {5'h0, mask, hit, r.st != BTP_IDLE};
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign pred_valid      = r.pv;
  assign pred_taken      = r.pt;
  assign pred_target     = r.ptgt;
  assign stall_cycles    = r.stall;
  assign stall_valid     = r.stv;
  assign next_pc         = r.pc;
  assign resolved_target = r.rtgt;

  hit_delay_a : assert property (
    @(posedge clk_sys) disable iff (reset)
    r.st == BTP_IDLE && next_r.st == BTP_WAIT |-> ##3 pred_valid)
    else $error("prediction not issued on time");
  disable_quiet_a : assert property (
    @(posedge clk_sys) disable iff (reset)
    !en |-> !upd.we)
    else $error("update while predictor disabled");
  freeze_hold_a : assert property (
    @(posedge clk_sys) disable iff (reset)
    frz |-> !upd.we && !upd.lru_we)
    else $error("entry changed while frozen");
  lock_keep_a : assert property (
    @(posedge clk_sys) disable iff (reset)
    upd.we && !rhit0 && !rhit1 |-> !(upd.way ? e1.lock : e0.lock))
    else $error("locked entry evicted");
  taken_skip_a : assert property (
    @(posedge clk_sys) disable iff (reset)
    next_r.st == BTP_WAIT && r.st == BTP_IDLE && next_r.h_taken
    |=> r.skip == 2'h2)
    else $error("taken skip window not loaded");
  skip_fetch_a : assert property (
    @(posedge clk_sys) disable iff (reset)
    r.skip != 2'h0 && fetch_valid |=> r.skip == $past(r.skip) - 2'h1)
    else $error("taken skip not counted by fetch");
  skip_hold_a : assert property (
    @(posedge clk_sys) disable iff (reset)
    r.skip != 2'h0 && !fetch_valid |=> r.skip == $past(r.skip))
    else $error("taken skip moved without fetch");
  upd_mask_a : assert property (
    @(posedge clk_sys) disable iff (reset)
    upd_busy && r.st == BTP_IDLE |=> r.st == BTP_IDLE)
    else $error("lookup during entry update");
  loop_skip_a : assert property (
    @(posedge clk_sys) disable iff (reset)
    loop_setup |=> r.loop_skip == 4'ha)
    else $error("loop setup window not loaded");
  tail_mask_a : assert property (
    @(posedge clk_sys) disable iff (reset)
    loop_active && near_end(fetch_addr, loop_end_addr, BTP_LOOP_TAIL)
    && r.st == BTP_IDLE |=> r.st == BTP_IDLE)
    else $error("lookup in loop tail");
  ret_mask_a : assert property (
    @(posedge clk_sys) disable iff (reset)
    fetch_is_ret && call_ret_in_pipe && r.st == BTP_IDLE
    |=> r.st == BTP_IDLE)
    else $error("return looked up with call or return in flight");
  stack_mask_a : assert property (
    @(posedge clk_sys) disable iff (reset)
    loop_stack_in_pipe && r.st == BTP_IDLE |=> r.st == BTP_IDLE)
    else $error("lookup during loop stack update");
  miss_cost_a : assert property (
    @(posedge clk_sys) disable iff (reset)
    en && res_valid && res_cond && res_pred_taken && !res_taken
    |=> stall_valid && stall_cycles == 4'hb)
    else $error("mispredict cost not eleven");
endmodule

// ==== btp_upd_if.sv ====
// Update channel between predictor core and entry store
`timescale 1ns/1ps
interface btp_upd_if;
  logic                        we;
  logic [btp_pkg::BTP_IDX_W-1:0] idx;
  logic                        way;
  btp_pkg::btp_entry_s         entry;
  logic                        lru_we;
  logic                        lru_val;
  modport src (output we, idx, way, entry, lru_we, lru_val);
  modport dst (input  we, idx, way, entry, lru_we, lru_val);
endinterface

// ==== btp_wb.sv ====
// Wishbone classic slave holding the predictor registers
`timescale 1ns/1ps
module btp_wb
  import btp_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [7:0]        stat_in,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  output logic [4:0]             predictor_config_reg,
  output logic [BTP_AW-1:0]      lock_range_start_reg,
  output logic [BTP_AW-1:0]      lock_range_end_reg
);
  typedef struct packed {
    logic [31:0]       dat;
    logic              ack;
    logic [4:0]        cfg;
    logic [BTP_AW-1:0] lst;
    logic [BTP_AW-1:0] lend;
  } btp_wb_s;
  btp_wb_s r;
  btp_wb_s next_r;

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      if (s[b]) o[b*8 +: 8] = n[b*8 +: 8];
    end
    return o;
  endfunction

  always_comb begin
    logic req;
    logic [31:0] c;
    req = wb_cyc_i && wb_stb_i && !r.ack;
    c = merge({27'h0, r.cfg}, wb_dat_i, wb_sel_i);
    next_r = r;
    next_r.ack = req;
    if (req && wb_we_i) begin
      unique case (wb_adr_i)
        BTP_OFS_CFG:   next_r.cfg = c[4:0];
        BTP_OFS_LSTRT: next_r.lst = merge(r.lst, wb_dat_i, wb_sel_i);
        BTP_OFS_LEND:  next_r.lend = merge(r.lend, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
    if (req) begin
      unique case (wb_adr_i)
        BTP_OFS_CFG:   next_r.dat = {27'h0, r.cfg};
        BTP_OFS_LSTRT: next_r.dat = r.lst;
        BTP_OFS_LEND:  next_r.dat = r.lend;
        BTP_OFS_STAT:  next_r.dat = {24'h0, stat_in};
        default:       next_r.dat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      r <= '{dat: 32'h0, ack: 1'b0, cfg: BTP_CFG_RST, lst: '0, lend: '0};
    end else begin
      r <= next_r;
    end
  end

  assign wb_dat_o             = r.dat;
  assign wb_ack_o             = r.ack;
  assign predictor_config_reg = r.cfg;
  assign lock_range_start_reg = r.lst;
  assign lock_range_end_reg   = r.lend;
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the branch target predictor
`timescale 1ns/1ps
`define CHK(x, y) \
  begin \
    checks_done++; \
    if ((x) !== (y)) begin \
      num_errors++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (x), (y)); \
    end \
  end
module tb_top
  import btp_pkg::*;
  ;
  logic              clk_sys, reset, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [3:0]        wb_adr_i, wb_sel_i, stall_cycles, stall_last;
  logic [31:0]       wb_dat_i, wb_dat_o, rd, a, t;
  logic              wb_ack_o, fetch_valid, res_valid, fetch_is_ret;
  logic [1:0]        fetch_len;
  logic [4:0]        res_f, pipe_f;
  logic [BTP_AW-1:0] fetch_addr, res_addr, res_target, loop_end, ret_top;
  logic [BTP_AW-1:0] ind_index, ind_modify, dir_base, dir_offset;
  logic              ind_sel, dir_rel, pred_valid, pred_taken;
  logic              stall_valid, stall_seen, vlen;
  logic [BTP_AW-1:0] pred_target, next_pc, resolved_target;
  int                num_errors, checks_done;

  btp_seq_model u_seq (
    .clk_sys(clk_sys), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .fetch_len(fetch_len), .res_valid(res_valid), .res_addr(res_addr),
    .res_target(res_target), .res_f(res_f), .pipe_f(pipe_f)
  );

  btp_top uut (
    .clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .fetch_len(fetch_len),
    .fetch_is_ret(fetch_is_ret), .call_ret_in_pipe(pipe_f[0]),
    .loop_stack_in_pipe(pipe_f[1]), .loop_setup(pipe_f[2]),
    .loop_active(pipe_f[3]), .loop_end_addr(loop_end),
    .ret_ahead(pipe_f[4]), .ret_stack_top(ret_top),
    .res_valid(res_valid), .res_addr(res_addr), .res_target(res_target),
    .res_taken(res_f[4]), .res_is_ret(res_f[3]),
    .res_pred_taken(res_f[2]), .res_delayed(res_f[1]),
    .res_cond(res_f[0]), .ind_sel(ind_sel), .ind_index(ind_index),
    .ind_modify(ind_modify), .dir_base(dir_base),
    .dir_offset(dir_offset), .dir_rel(dir_rel),
    .pred_valid(pred_valid), .pred_taken(pred_taken),
    .pred_target(pred_target), .stall_cycles(stall_cycles),
    .stall_valid(stall_valid), .next_pc(next_pc),
    .resolved_target(resolved_target)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Cost pulses are short, so latch them rather than chase their cycle
  always @(posedge clk_sys) begin
    if (stall_valid === 1'b1) begin
      stall_seen <= 1'b1;
      stall_last <= stall_cycles;
    end
  end

  function automatic logic [3:0] cost(input logic pt, tk, dl);
    if (pt && tk) return dl ? 4'h0 : BTP_COST_HIT_ND;
    if (pt || tk) return (tk && dl) ? BTP_COST_NT_DB : BTP_COST_MISS;
    return 4'h0;
  endfunction

  function automatic logic [31:0] tgt_exp();
    if (ind_sel) return ind_index + ind_modify * (vlen ? 32'h1 : 32'h3);
    return dir_rel ? dir_base + dir_offset : dir_offset;
  endfunction

  // Each target source in turn, with a fresh modify value
  task automatic srcs();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      {ind_sel, dir_rel} <= 2'(i);
      ind_modify <= $urandom;
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK(resolved_target, tgt_exp())
    end
  endtask

  task automatic print_verdict();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic wb(input logic we, input logic [3:0] ad,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= ad;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      num_errors++;
      print_verdict();
    end
    if (we) repeat (12) @(posedge clk_sys);
  endtask

  task automatic probe(input logic [31:0] ad, input logic v, tk);
    u_seq.fetch(ad);
    for (int i = 1; i <= 5; i++) begin
      @(posedge clk_sys);
      #1;
      `CHK(pred_valid, v && i == 2)
      if (i == 1) `CHK(next_pc, ad + (vlen ? 32'h3 : 32'h1))
      if (v && i == 2) begin
        `CHK(pred_taken, tk)
        if (tk) `CHK(pred_target, t)
      end
    end
  endtask

  // A taken guess hides the next two fetches from the predictor
  task automatic look(input logic v, tk);
    probe(a, v, tk);
    if (v && tk) repeat (2) probe(a, 1'b0, 1'b0);
  endtask

  task automatic res(input logic pt, tk, dl);
    stall_seen = 1'b0;
    u_seq.resolve(a, t, {tk, 1'b0, pt, dl, 1'b1});
    `CHK(stall_seen, 1'b1)
    `CHK(stall_last, cost(pt, tk, dl))
  endtask

  initial begin
    void'($urandom(98417));
    reset = 1'b1;
    vlen = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, fetch_is_ret} = 4'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = {4'h0, 4'hf, 32'h0};
    {loop_end, ret_top, ind_index} = {$urandom, $urandom, $urandom};
    {ind_modify, dir_base, dir_offset} = {$urandom, $urandom, $urandom};
    {ind_sel, dir_rel} = 2'($urandom);
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    wb(1'b0, BTP_OFS_CFG, 32'h0, rd);
    `CHK(rd, {27'h0, BTP_CFG_RST})
    wb(1'b0, 4'h2, 32'h0, rd);
    `CHK(rd, 32'h0)
    a = $urandom & 32'hffff_fff0;
    wb(1'b1, BTP_OFS_LEND, a, rd);
    wb(1'b0, BTP_OFS_LEND, 32'h0, rd);
    `CHK(rd, a)
    a = $urandom & 32'hffff_fff0;
    t = $urandom;
    look(1'b0, 1'b0);
    res(1'b0, 1'b1, 1'b0);
    look(1'b1, 1'b0);
    res(1'b0, 1'b1, 1'b0);
    look(1'b1, 1'b1);
    wb(1'b1, BTP_OFS_CFG, 32'h0b, rd);
    look(1'b1, 1'b1);
    res(1'b1, 1'b0, 1'b0);
    res(1'b1, 1'b0, 1'b0);
    wb(1'b1, BTP_OFS_CFG, 32'h09, rd);
    look(1'b1, 1'b1);
    wb(1'b1, BTP_OFS_CFG, 32'h08, rd);
    look(1'b0, 1'b0);
    wb(1'b1, BTP_OFS_CFG, 32'h09, rd);
    u_seq.flags(5'h02);
    look(1'b0, 1'b0);
    u_seq.flags(5'h00);
    look(1'b1, 1'b1);
    fetch_is_ret <= 1'b1;
    u_seq.flags(5'h01);
    look(1'b0, 1'b0);
    fetch_is_ret <= 1'b0;
    u_seq.flags(5'h04);
    u_seq.flags(5'h00);
    repeat (10) probe(a, 1'b0, 1'b0);
    look(1'b1, 1'b1);
    for (int i = 0; i < 8; i++) begin
      res(i[0], i[1], i[2]);
    end
    srcs();
    wb(1'b1, BTP_OFS_CFG, 32'h19, rd);
    vlen = 1'b1;
    probe(a + 32'h80, 1'b0, 1'b0);
    srcs();
    print_verdict();
  end
endmodule
